//--- udm_pkg.sv
// constants, register map and state types of the interrupt-driven micro dma engine
package udm_pkg;
	localparam int NCH = 4;
	localparam int AXI_AW = 8;
	localparam int BUS_AW = 24;
	localparam int VEC_W = 9;
	localparam int CLK_NS = 10;
	localparam int STATE_NS = 100;
	localparam int STATE_CYC = (STATE_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [3:0] STATE_LAST = 4'(STATE_CYC - 1);
	localparam logic [4:0] ST_COPY = 5'h10;
	localparam logic [4:0] ST_REFRESH = 5'h0e;
	localparam logic [4:0] ST_COUNT = 5'h0b;
	localparam logic [8:0] VEC_PRIV = 9'h010;
	localparam logic [8:0] VEC_UNDEF = 9'h020;
	localparam logic [8:0] VEC_RX0 = 9'h180;
	localparam logic [8:0] VEC_AD = 9'h1c0;
	localparam logic [4:0] SV_FIRST = 5'h08;
	localparam logic [4:0] SV_LAST = 5'h1c;
	localparam logic [15:0] ENTRY_BASE = 16'h8000;
	localparam logic [15:0] ENTRY_PRIV = 16'h8010;
	localparam logic [15:0] ENTRY_UNDEF = 16'h8020;
	localparam logic [15:0] ENTRY_AD = 16'h81c0;
	localparam logic [2:0] M_DST_INC = 3'h0;
	localparam logic [2:0] M_DST_DEC = 3'h1;
	localparam logic [2:0] M_SRC_INC = 3'h2;
	localparam logic [2:0] M_SRC_DEC = 3'h3;
	localparam logic [2:0] M_FIXED = 3'h4;
	localparam logic [3:0] M_REFRESH = 4'ha;
	localparam logic [3:0] M_COUNT = 4'hb;
	localparam logic [15:0] REFRESH_STEP = 16'h0004;
	localparam logic [1:0] REFRESH_LAST = 2'h3;
	localparam logic [7:0] OFF_SRC = 8'h00;
	localparam logic [7:0] OFF_DST = 8'h04;
	localparam logic [7:0] OFF_CNT = 8'h08;
	localparam logic [7:0] OFF_MODE = 8'h0c;
	localparam logic [7:0] OFF_SVEC = 8'h40;
	localparam logic [7:0] OFF_STATUS = 8'h50;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {
		UDM_IDLE = 2'b00,
		UDM_READ = 2'b01,
		UDM_WRITE = 2'b11,
		UDM_FINISH = 2'b10
	} udm_fsm_t;
endpackage : udm_pkg

//--- udm_engine.sv
// four-channel interrupt-driven micro dma engine with axi4-lite register access
// How it works
// - privilege fault vector 010h, entry 8010h, no dma
// - bad opcode entry 8020h, never dma serviced
// - serial0 receive vector 180h, start vector 18h
// - conversion done 1c0h entry 81c0h, 1d0h-1f0h reserved
// - acceptance answers vector with dma or ordinary flag
// - dma only on start vector match, four channels
// - one transfer, decrement, zero gives ordinary interrupt except in refresh mode
// - 32-bit address registers, 24 bits on bus
// - byte or word, addresses increment, decrement, fixed
// - 16-bit counter, zero start gives 65536 transfers
// - after zero, next request counts 65536 again
// - channel registers writable only by privileged access
// - modes 000x/001x step destination, 16 states minimum
// - modes 010x/011x step source, 100x fixed, 16 states
// - refresh reads four bytes, low word plus 4
// - counter mode: no bus, source plus one, 11 states
// - state counts assume 16-bit zero-wait bus, 100 ns
// - dma reaches the whole system address space
// - bus granted away holds off interrupt acceptance
// - start vector compared with vector bits 8..4
// - several matches: lowest channel number wins
//
// Implementation choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module udm_engine (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [udm_pkg::AXI_AW-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [udm_pkg::AXI_AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic int_accept,
	input wire logic [udm_pkg::VEC_W-1:0] int_vector,
	output logic int_accept_ready,
	output logic svc_valid,
	output logic svc_is_dma,
	output logic [1:0] svc_channel,
	output logic [15:0] svc_entry,
	output logic irq_valid,
	output logic [15:0] irq_entry,
	output logic sys_req,
	output logic sys_write,
	output logic sys_word,
	output logic [udm_pkg::BUS_AW-1:0] sys_addr,
	output logic [15:0] sys_wdata,
	input wire logic sys_ack,
	input wire logic [15:0] sys_rdata,
	input wire logic bus_grant_acknowledge_n
);
	import udm_pkg::*;

	typedef struct packed {
		logic [NCH-1:0][31:0] src;
		logic [NCH-1:0][31:0] dst;
		logic [NCH-1:0][15:0] cnt;
		logic [NCH-1:0][7:0] mode;
		logic [NCH-1:0][4:0] svec;
		logic aw_done;
		logic aw_priv;
		logic [AXI_AW-1:0] aw_addr;
		logic w_done;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		udm_fsm_t fsm;
		logic [1:0] ch;
		logic [1:0] beat;
		logic [3:0] div;
		logic [4:0] states;
		logic [15:0] buf16;
		logic req;
		logic write;
		logic word;
		logic [BUS_AW-1:0] addr;
		logic [15:0] bus_wdata;
		logic svc_valid;
		logic svc_dma;
		logic [1:0] svc_ch;
		logic [15:0] svc_entry;
		logic irq_valid;
		logic [15:0] irq_entry;
		logic grant_meta;
		logic grant_sync;
	} udm_state_t;

	udm_state_t s_q;
	udm_state_t s_d;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
		begin
			if (strb[i])
				r[i*8 +: 8] = nw[i*8 +: 8];
		end
		return r;
	endfunction : merge

	// only the 64-byte channel block, start vectors and status are mapped
	function automatic logic mapped(input logic [AXI_AW-1:0] a);
		return (a < OFF_SVEC) || (a[7:4] == OFF_SVEC[7:4]) || (a == OFF_STATUS);
	endfunction : mapped

	function automatic logic [4:0] min_states(input logic [3:0] m);
		if (m == M_REFRESH)
			return ST_REFRESH;
		else if (m == M_COUNT)
			return ST_COUNT;
		return ST_COPY;
	endfunction : min_states

	function automatic logic [31:0] size_step(input logic [3:0] m);
		return m[0] ? 32'h0000_0002 : 32'h0000_0001;
	endfunction : size_step

	// maskable sources 080h..1c0h carry a start vector; cpu traps and reserved ones do not
	function automatic logic eligible(input logic [VEC_W-1:0] v);
		return (v[3:0] == 4'h0) && (v[8:4] >= SV_FIRST) && (v[8:4] <= SV_LAST);
	endfunction : eligible

	logic bus_held;
	logic hit;
	logic [1:0] hit_ch;
	logic [3:0] cur_mode;
	logic [15:0] cnt_dec;

	assign bus_held = ~s_q.grant_sync;
	assign cur_mode = s_q.mode[s_q.ch][3:0];
	assign cnt_dec = s_q.cnt[s_q.ch] - 16'h0001;

	always_comb
	begin
		hit = 1'b0;
		hit_ch = 2'h0;
		for (int i = NCH - 1; i >= 0; i--)
		begin
			if (eligible(int_vector) && s_q.svec[i] == int_vector[8:4])
			begin
				hit = 1'b1;
				hit_ch = 2'(i);
			end
		end
	end

	// new transfers are taken only when idle and the bus is ours
	assign int_accept_ready = (s_q.fsm == UDM_IDLE) && !bus_held;

	always_comb
	begin
		logic [31:0] wv;
		logic [1:0] wch;
		logic [2:0] sel;
		wv = 32'h0;
		wch = 2'h0;
		sel = 3'h0;
		s_d = s_q;
		s_d.grant_meta = bus_grant_acknowledge_n;
		s_d.grant_sync = s_q.grant_meta;
		s_d.svc_valid = 1'b0;
		s_d.irq_valid = 1'b0;

		// engine
		if (s_q.fsm != UDM_IDLE)
		begin
			if (s_q.div == STATE_LAST)
			begin
				s_d.div = 4'h0;
				if (s_q.states != 5'h1f)
					s_d.states = s_q.states + 5'h01;
			end
			else
				s_d.div = s_q.div + 4'h1;
		end
		unique case (s_q.fsm)
			UDM_IDLE:
			begin
				if (int_accept && int_accept_ready)
				begin
					s_d.svc_valid = 1'b1;
					s_d.svc_dma = hit;
					s_d.svc_ch = hit_ch;
					s_d.svc_entry = ENTRY_BASE + {7'h00, int_vector};
					if (hit)
					begin
						s_d.ch = hit_ch;
						s_d.div = 4'h0;
						s_d.states = 5'h00;
						s_d.beat = 2'h0;
						if (s_q.mode[hit_ch][3:0] == M_COUNT)
							s_d.fsm = UDM_FINISH;
						else
						begin
							s_d.fsm = UDM_READ;
							s_d.req = 1'b1;
							s_d.write = 1'b0;
							s_d.word = (s_q.mode[hit_ch][3:0] != M_REFRESH) && s_q.mode[hit_ch][0];
							s_d.addr = s_q.src[hit_ch][BUS_AW-1:0];
						end
					end
				end
			end
			UDM_READ:
			begin
				if (sys_ack)
				begin
					if (cur_mode == M_REFRESH)
					begin
						s_d.beat = s_q.beat + 2'h1;
						if (s_q.beat == REFRESH_LAST)
						begin
							s_d.req = 1'b0;
							s_d.fsm = UDM_FINISH;
						end
						else
							s_d.addr = s_q.src[s_q.ch][BUS_AW-1:0] + {22'h0, s_q.beat} + 24'h1;
					end
					else
					begin
						s_d.buf16 = sys_rdata;
						s_d.fsm = UDM_WRITE;
						s_d.write = 1'b1;
						s_d.addr = s_q.dst[s_q.ch][BUS_AW-1:0];
						s_d.bus_wdata = s_q.word ? sys_rdata : {8'h00, sys_rdata[7:0]};
					end
				end
			end
			UDM_WRITE:
			begin
				if (sys_ack)
				begin
					s_d.req = 1'b0;
					s_d.write = 1'b0;
					s_d.fsm = UDM_FINISH;
				end
			end
			UDM_FINISH:
			begin
				// bus work is done; pad to the minimum state count, then update
				if (s_q.states >= min_states(cur_mode))
				begin
					s_d.fsm = UDM_IDLE;
					s_d.cnt[s_q.ch] = cnt_dec;
					if (cur_mode == M_REFRESH)
						s_d.src[s_q.ch][15:0] = s_q.src[s_q.ch][15:0] + REFRESH_STEP;
					else if (cur_mode == M_COUNT)
						s_d.src[s_q.ch] = s_q.src[s_q.ch] + 32'h1;
					else
					begin
						unique case (cur_mode[3:1])
							M_DST_INC: s_d.dst[s_q.ch] = s_q.dst[s_q.ch] + size_step(cur_mode);
							M_DST_DEC: s_d.dst[s_q.ch] = s_q.dst[s_q.ch] - size_step(cur_mode);
							M_SRC_INC: s_d.src[s_q.ch] = s_q.src[s_q.ch] + size_step(cur_mode);
							M_SRC_DEC: s_d.src[s_q.ch] = s_q.src[s_q.ch] - size_step(cur_mode);
							default: ; // fixed mode, and codes software must not use
						endcase
					end
					if (cur_mode != M_REFRESH && cnt_dec == 16'h0000)
					begin
						s_d.irq_valid = 1'b1;
						s_d.irq_entry = s_q.svc_entry;
					end
				end
			end
		endcase

		// axi write channel; a software write lands after the engine update and wins
		if (s_axi_awvalid && s_axi_awready)
		begin
			s_d.aw_done = 1'b1;
			s_d.aw_addr = s_axi_awaddr;
			s_d.aw_priv = s_axi_awprot[0];
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			s_d.w_done = 1'b1;
			s_d.wdata = s_axi_wdata;
			s_d.wstrb = s_axi_wstrb;
		end
		if (s_axi_bvalid && s_axi_bready)
			s_d.bvalid = 1'b0;
		if (s_q.aw_done && s_q.w_done && !s_q.bvalid)
		begin
			s_d.aw_done = 1'b0;
			s_d.w_done = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp = RESP_OKAY;
			wch = s_q.aw_addr[5:4];
			sel = {1'b0, s_q.aw_addr[3:2]};
			if (!mapped(s_q.aw_addr))
				s_d.bresp = RESP_SLVERR;
			else if (s_q.aw_addr < OFF_SVEC)
			begin
				if (!s_q.aw_priv)
					s_d.bresp = RESP_SLVERR;
				else
				begin
					unique case (sel[1:0])
						OFF_SRC[3:2]: s_d.src[wch] = merge(s_d.src[wch], s_q.wdata, s_q.wstrb);
						OFF_DST[3:2]: s_d.dst[wch] = merge(s_d.dst[wch], s_q.wdata, s_q.wstrb);
						OFF_CNT[3:2]:
						begin
							wv = merge({16'h0, s_d.cnt[wch]}, s_q.wdata, s_q.wstrb);
							s_d.cnt[wch] = wv[15:0];
						end
						OFF_MODE[3:2]:
						begin
							wv = merge({24'h0, s_d.mode[wch]}, s_q.wdata, s_q.wstrb);
							s_d.mode[wch] = wv[7:0];
						end
					endcase
				end
			end
			else if (s_q.aw_addr[7:4] == OFF_SVEC[7:4])
			begin
				wv = merge({27'h0, s_q.svec[s_q.aw_addr[3:2]]}, s_q.wdata, s_q.wstrb);
				s_d.svec[s_q.aw_addr[3:2]] = wv[4:0];
			end
		end

		// axi read channel
		if (s_axi_rvalid && s_axi_rready)
			s_d.rvalid = 1'b0;
		if (s_axi_arvalid && s_axi_arready)
		begin
			s_d.rvalid = 1'b1;
			s_d.rresp = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
			s_d.rdata = 32'h0;
			if (s_axi_araddr < OFF_SVEC)
			begin
				unique case (s_axi_araddr[3:2])
					OFF_SRC[3:2]: s_d.rdata = s_q.src[s_axi_araddr[5:4]];
					OFF_DST[3:2]: s_d.rdata = s_q.dst[s_axi_araddr[5:4]];
					OFF_CNT[3:2]: s_d.rdata = {16'h0, s_q.cnt[s_axi_araddr[5:4]]};
					OFF_MODE[3:2]: s_d.rdata = {24'h0, s_q.mode[s_axi_araddr[5:4]]};
				endcase
			end
			else if (s_axi_araddr[7:4] == OFF_SVEC[7:4])
				s_d.rdata = {27'h0, s_q.svec[s_axi_araddr[3:2]]};
			else if (s_axi_araddr == OFF_STATUS)
				s_d.rdata = {24'h0, bus_held, s_q.fsm, s_q.ch, s_q.fsm != UDM_IDLE, 2'h0};
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s_q <= '0;
			s_q.fsm <= UDM_IDLE;
		end
		else
			s_q <= s_d;
	end

	assign s_axi_awready = !s_q.aw_done && !s_q.bvalid;
	assign s_axi_wready = !s_q.w_done && !s_q.bvalid;
	assign s_axi_bvalid = s_q.bvalid;
	assign s_axi_bresp = s_q.bresp;
	assign s_axi_arready = !s_q.rvalid;
	assign s_axi_rvalid = s_q.rvalid;
	assign s_axi_rdata = s_q.rdata;
	assign s_axi_rresp = s_q.rresp;
	assign svc_valid = s_q.svc_valid;
	assign svc_is_dma = s_q.svc_dma;
	assign svc_channel = s_q.svc_ch;
	assign svc_entry = s_q.svc_entry;
	assign irq_valid = s_q.irq_valid;
	assign irq_entry = s_q.irq_entry;
	assign sys_req = s_q.req;
	assign sys_write = s_q.write;
	assign sys_word = s_q.word;
	assign sys_addr = s_q.addr;
	assign sys_wdata = s_q.bus_wdata;

	// assertion helpers: cycles since start of a transfer and bus reads acknowledged
	logic [8:0] elapsed_q;
	logic [2:0] reads_q;
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			elapsed_q <= 9'h0;
			reads_q <= 3'h0;
		end
		else if (s_q.fsm == UDM_IDLE)
		begin
			elapsed_q <= 9'h0;
			reads_q <= 3'h0;
		end
		else
		begin
			elapsed_q <= elapsed_q + 9'h1;
			if (sys_req && sys_ack && !sys_write)
				reads_q <= reads_q + 3'h1;
		end
	end

	sequence s_take;
		int_accept && int_accept_ready;
	endsequence

	sequence s_done;
		(s_q.fsm == UDM_FINISH) ##1 (s_q.fsm == UDM_IDLE);
	endsequence

	// pin low two samples ago must already have closed acceptance
	property p_hold_off;
		@(posedge clk) disable iff (!rst_n)
			!$past(bus_grant_acknowledge_n, 2) |-> !int_accept_ready;
	endproperty
	a_hold_off: assert property (p_hold_off) else $error("accept open while bus away");

	property p_priv_vec;
		@(posedge clk) disable iff (!rst_n)
			(s_take and (int_vector == VEC_PRIV)) |=> svc_valid && !svc_is_dma
			&& svc_entry == ENTRY_PRIV;
	endproperty
	a_priv_vec: assert property (p_priv_vec) else $error("privilege fault answer wrong");

	property p_undef_vec;
		@(posedge clk) disable iff (!rst_n)
			(s_take and (int_vector == VEC_UNDEF)) |=> !svc_is_dma && svc_entry == ENTRY_UNDEF;
	endproperty
	a_undef_vec: assert property (p_undef_vec) else $error("bad opcode answer wrong");

	property p_ad_vec;
		@(posedge clk) disable iff (!rst_n)
			(s_take and (int_vector == VEC_AD)) |=> svc_entry == ENTRY_AD;
	endproperty
	a_ad_vec: assert property (p_ad_vec) else $error("conversion done entry wrong");

	property p_lowest_ch;
		@(posedge clk) disable iff (!rst_n)
			(s_take and (int_vector[8:4] == s_q.svec[0]) and (int_vector == VEC_RX0))
			|=> svc_is_dma && svc_channel == 2'h0 && s_q.fsm != UDM_IDLE;
	endproperty
	a_lowest_ch: assert property (p_lowest_ch) else $error("channel 0 not chosen");

	property p_min_time;
		@(posedge clk) disable iff (!rst_n)
			s_done |-> $past(elapsed_q) >= 9'(min_states($past(cur_mode)) * STATE_CYC - 1);
	endproperty
	a_min_time: assert property (p_min_time) else $error("transfer shorter than minimum");

	property p_count_nobus;
		@(posedge clk) disable iff (!rst_n)
			(s_q.fsm != UDM_IDLE && cur_mode == M_COUNT) |-> !sys_req;
	endproperty
	a_count_nobus: assert property (p_count_nobus) else $error("counter mode used the bus");

	property p_refresh_quiet;
		@(posedge clk) disable iff (!rst_n)
			(s_q.fsm == UDM_FINISH && cur_mode == M_REFRESH) |=> !irq_valid;
	endproperty
	a_refresh_quiet: assert property (p_refresh_quiet) else $error("refresh raised interrupt");

	property p_refresh_beats;
		@(posedge clk) disable iff (!rst_n)
			(s_q.fsm == UDM_FINISH && cur_mode == M_REFRESH) |-> reads_q == 3'h4;
	endproperty
	a_refresh_beats: assert property (p_refresh_beats) else $error("refresh read count wrong");

	property p_zero_irq;
		@(posedge clk) disable iff (!rst_n)
			(s_q.fsm == UDM_FINISH && s_d.fsm == UDM_IDLE && cur_mode != M_REFRESH)
			|=> irq_valid == (s_q.cnt[s_q.ch] == 16'h0000);
	endproperty
	a_zero_irq: assert property (p_zero_irq) else $error("zero count interrupt wrong");

	property p_priv_write;
		@(posedge clk) disable iff (!rst_n)
			// the engine's own register update only lands in the finish state
			(s_q.aw_done && s_q.w_done && !s_q.bvalid && !s_q.aw_priv && s_q.aw_addr < OFF_SVEC
			&& s_q.fsm != UDM_FINISH)
			|=> s_axi_bresp == RESP_SLVERR && $stable(s_q.mode) && $stable(s_q.src)
			&& $stable(s_q.dst) && $stable(s_q.cnt);
	endproperty
	a_priv_write: assert property (p_priv_write) else $error("unprivileged write took effect");
endmodule : udm_engine

//--- udm_mem_model.sv
// memory and i/o model on the far side of the dma system bus
`timescale 1ns/1ps
module udm_mem_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic sys_req,
	input wire logic sys_write,
	input wire logic [23:0] sys_addr,
	input wire logic [15:0] sys_wdata,
	output logic sys_ack,
	output logic [15:0] sys_rdata,
	input wire logic [3:0] delay,
	output int rd_cnt,
	output int wr_cnt,
	output logic [23:0] rd_addr,
	output logic [23:0] wr_addr,
	output logic [15:0] wr_data
);
	logic [3:0] wait_q;
	logic [15:0] last_q;
	// read data depends on the address only, so the bench can predict it
	assign sys_rdata = (sys_ack && !sys_write) ? (sys_addr[15:0] ^ 16'h5a5a) : ~last_q;
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sys_ack <= 1'b0;
			wait_q <= 4'h0;
			last_q <= 16'h0;
			rd_cnt <= 0;
			wr_cnt <= 0;
			rd_addr <= 24'h0;
			wr_addr <= 24'h0;
			wr_data <= 16'h0;
		end
		else if (sys_ack)
		begin
			// one-cycle ack; released data lines show the inverse of the last value
			sys_ack <= 1'b0;
			wait_q <= 4'h0;
			last_q <= sys_rdata;
		end
		else if (sys_req && wait_q == delay)
		begin
			sys_ack <= 1'b1;
			if (sys_write)
			begin
				wr_cnt <= wr_cnt + 1;
				wr_addr <= sys_addr;
				wr_data <= sys_wdata;
			end
			else
			begin
				rd_cnt <= rd_cnt + 1;
				rd_addr <= sys_addr;
			end
		end
		else if (sys_req)
			wait_q <= wait_q + 4'h1;
	end
endmodule : udm_mem_model

//--- test_interrupt_driven_micro_dma.sv
// self-checking testbench of the micro dma engine
`timescale 1ns/1ps
module test_interrupt_driven_micro_dma;
	import udm_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
	logic [2:0] s_axi_awprot = 3'h0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, svc_channel;
	logic int_accept = 1'b0;
	logic [8:0] int_vector = 9'h0;
	logic int_accept_ready, svc_valid, svc_is_dma, irq_valid;
	logic [15:0] svc_entry, irq_entry, sys_wdata, sys_rdata, m_wdata;
	logic sys_req, sys_write, sys_word, sys_ack;
	logic [23:0] sys_addr, m_raddr, m_waddr;
	logic bus_grant_acknowledge_n = 1'b1;
	logic [3:0] mem_delay = 4'h0;
	int m_rd, m_wr, r0, w0;
	int miscompares = 0;
	int checks = 0;
	logic m_word;
	logic [31:0] sd [5] = '{32'h0, 32'h0, 32'h1, 32'hffffffff, 32'h0};
	logic [31:0] dd [5] = '{32'h1, 32'hffffffff, 32'h0, 32'h0, 32'h0};
	always #5 clk = ~clk;
	// width of the last write taken on the system bus
	always @(posedge clk)
		if (sys_req && sys_ack && sys_write)
			m_word <= sys_word;
	udm_engine udm_engine_inst (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awprot(s_axi_awprot), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(1'b1), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(1'b1), .int_accept(int_accept),
		.int_vector(int_vector), .int_accept_ready(int_accept_ready), .svc_valid(svc_valid),
		.svc_is_dma(svc_is_dma), .svc_channel(svc_channel), .svc_entry(svc_entry),
		.irq_valid(irq_valid), .irq_entry(irq_entry), .sys_req(sys_req), .sys_write(sys_write),
		.sys_word(sys_word), .sys_addr(sys_addr), .sys_wdata(sys_wdata), .sys_ack(sys_ack),
		.sys_rdata(sys_rdata), .bus_grant_acknowledge_n(bus_grant_acknowledge_n));
	udm_mem_model udm_mem_model_inst (.clk(clk), .rst_n(rst_n), .sys_req(sys_req),
		.sys_write(sys_write), .sys_addr(sys_addr), .sys_wdata(sys_wdata), .sys_ack(sys_ack),
		.sys_rdata(sys_rdata), .delay(mem_delay), .rd_cnt(m_rd), .wr_cnt(m_wr),
		.rd_addr(m_raddr), .wr_addr(m_waddr), .wr_data(m_wdata));
	task automatic conclude;
		if (miscompares == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : conclude
	task automatic stall;
		miscompares++;
		conclude();
	endtask : stall
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e)
		begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [2:0] p,
		input logic [1:0] er);
		int n;
		n = 0;
		s_axi_awaddr <= a;
		s_axi_awprot <= p;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		repeat (51)
		begin
			@(posedge clk);
			n++;
			if (n > 50)
				stall();
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid === 1'b1)
			begin
				chk($sformatf("bresp %h", a), 32'(er), 32'(s_axi_bresp));
				break;
			end
		end
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		int n;
		n = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		repeat (51)
		begin
			@(posedge clk);
			n++;
			if (n > 50)
				stall();
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid === 1'b1)
			begin
				chk($sformatf("rdata %h", a), e, s_axi_rdata);
				chk("rresp", 32'(er), 32'(s_axi_rresp));
				break;
			end
		end
	endtask : rd
	task automatic setup(input logic [7:0] b, input logic [31:0] s, d, c, m);
		wr(b + OFF_SRC, s, 3'h1, RESP_OKAY);
		wr(b + OFF_DST, d, 3'h1, RESP_OKAY);
		wr(b + OFF_CNT, c, 3'h1, RESP_OKAY);
		wr(b + OFF_MODE, m, 3'h1, RESP_OKAY);
	endtask : setup
	// accept one vector, check the answer, then watch the transfer end and any irq
	task automatic run(input logic [8:0] v, input logic dma, input logic [1:0] ch, input int st,
		input int ni);
		int n;
		int seen;
		int rdy;
		logic [15:0] ent;
		n = 0;
		seen = 0;
		rdy = 0;
		ent = ENTRY_BASE + 16'(v);
		while (int_accept_ready !== 1'b1)
		begin
			@(posedge clk);
			n++;
			if (n > 500)
				stall();
		end
		int_accept <= 1'b1;
		int_vector <= v;
		@(posedge clk);
		int_accept <= 1'b0;
		@(posedge clk);
		chk("svc_valid", 32'h1, 32'(svc_valid));
		chk("svc_is_dma", 32'(dma), 32'(svc_is_dma));
		if (dma)
			chk("svc_channel", 32'(ch), 32'(svc_channel));
		chk("svc_entry", 32'(ent), 32'(svc_entry));
		n = 1;
		repeat (st * 10 + 30)
		begin
			@(posedge clk);
			n++;
			if (irq_valid === 1'b1)
			begin
				seen++;
				chk("irq_entry", 32'(ent), 32'(irq_entry));
			end
			if (rdy == 0 && int_accept_ready === 1'b1)
				rdy = n;
		end
		chk("irq_count", 32'(ni), 32'(seen));
		if (dma)
			chk("duration", 32'h1, 32'(rdy >= st * 10 - 1 && rdy <= st * 10 + 20));
	endtask : run
	initial
	begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		rd(8'h60, 32'h0, RESP_SLVERR);
		rd(OFF_SRC, 32'h0, RESP_OKAY);
		wr(OFF_SRC, 32'h1, 3'h0, RESP_SLVERR);
		rd(OFF_SRC, 32'h0, RESP_OKAY);
		setup(8'h00, 32'hab000010, 32'h200, 32'h2, 32'h1);
		wr(OFF_SVEC, 32'h18, 3'h0, RESP_OKAY);
		run(VEC_RX0, 1'b1, 2'h0, 16, 0);
		chk("rd_addr", 32'h10, 32'(m_raddr));
		chk("wr_addr", 32'h200, 32'(m_waddr));
		chk("wr_data", 32'h5a4a, 32'(m_wdata));
		chk("wr_word", 32'h1, 32'(m_word));
		rd(OFF_SRC, 32'hab000010, RESP_OKAY);
		rd(OFF_DST, 32'h202, RESP_OKAY);
		rd(OFF_CNT, 32'h1, RESP_OKAY);
		run(VEC_RX0, 1'b1, 2'h0, 16, 1);
		rd(OFF_CNT, 32'h0, RESP_OKAY);
		run(VEC_RX0, 1'b1, 2'h0, 16, 0);
		rd(OFF_CNT, 32'hffff, RESP_OKAY);
		mem_delay <= 4'h3;
		for (int i = 0; i < 5; i++)
		begin
			setup(8'h00, 32'h100, 32'h200, 32'h5, 32'(i * 2));
			run(VEC_RX0, 1'b1, 2'h0, 16, 0);
			rd(OFF_SRC, 32'h100 + sd[i], RESP_OKAY);
			rd(OFF_DST, 32'h200 + dd[i], RESP_OKAY);
			chk("byte_data", 32'h5a, 32'(m_wdata));
			chk("byte_word", 32'h0, 32'(m_word));
		end
		r0 = m_rd;
		setup(8'h00, 32'h1234fffe, 32'h0, 32'h1, 32'ha);
		run(VEC_RX0, 1'b1, 2'h0, 14, 0);
		rd(OFF_SRC, 32'h12340002, RESP_OKAY);
		chk("refresh_reads", 32'h4, 32'(m_rd - r0));
		r0 = m_rd;
		w0 = m_wr;
		setup(8'h00, 32'h5, 32'h0, 32'h1, 32'hb);
		run(VEC_RX0, 1'b1, 2'h0, 11, 1);
		rd(OFF_SRC, 32'h6, RESP_OKAY);
		chk("bus_accesses", 32'(r0 + w0), 32'(m_rd + m_wr));
		run(VEC_PRIV, 1'b0, 2'h0, 0, 0);
		wr(OFF_SVEC + 8'h4, 32'h02, 3'h0, RESP_OKAY);
		run(VEC_UNDEF, 1'b0, 2'h0, 0, 0);
		wr(OFF_SVEC + 8'hc, 32'h1d, 3'h0, RESP_OKAY);
		run(9'h1d0, 1'b0, 2'h0, 0, 0);
		setup(8'h10, 32'h300, 32'h400, 32'h3, 32'h8);
		wr(OFF_SVEC + 8'h4, 32'h1c, 3'h0, RESP_OKAY);
		wr(OFF_SVEC + 8'h8, 32'h1c, 3'h0, RESP_OKAY);
		run(VEC_AD, 1'b1, 2'h1, 16, 0);
		bus_grant_acknowledge_n <= 1'b0;
		repeat (4) @(posedge clk);
		chk("accept_ready", 32'h0, 32'(int_accept_ready));
		int_accept <= 1'b1;
		int_vector <= VEC_RX0;
		@(posedge clk);
		int_accept <= 1'b0;
		@(posedge clk);
		chk("svc_valid", 32'h0, 32'(svc_valid));
		bus_grant_acknowledge_n <= 1'b1;
		repeat (4) @(posedge clk);
		chk("accept_ready", 32'h1, 32'(int_accept_ready));
		conclude();
	end
endmodule : test_interrupt_driven_micro_dma
